// [enc_pos_pkg.sv]
package enc_pos_pkg;

  // ****************************************
  // register indices, byte address = 4 x index
  // ****************************************
  localparam logic [7:0] IDX_MASK = 8'h37;
  localparam logic [7:0] IDX_CONFIG = 8'h38;
  localparam logic [7:0] IDX_COUNT = 8'h39;
  localparam logic [7:0] IDX_FACTOR = 8'h3A;
  localparam logic [7:0] IDX_FLAGS = 8'h3B;
  localparam logic [7:0] IDX_CAPTURE = 8'h3C;
  localparam logic [7:0] IDX_THRESH = 8'h3D;

  // ****************************************
  // field positions and widths
  // ****************************************
  localparam int CFG_POL_A = 0;
  localparam int CFG_POL_B = 1;
  localparam int CFG_POL_N = 2;
  localparam int CFG_SKIP_QUAD = 3;
  localparam int CFG_CONT = 4;
  localparam int CFG_ONCE = 5;
  localparam int CFG_EDGE_LSB = 6;
  localparam int CFG_CLR_COUNT = 8;
  localparam int CFG_LATCH_RAMP = 9;
  localparam int CFG_DECIMAL = 10;
  localparam int CFG_WIDTH = 11;
  localparam int FLAG_INDEX = 0;
  localparam int FLAG_SLIP = 1;
  localparam int FLAG_WIDTH = 2;
  localparam int THRESH_WIDTH = 20;
  localparam int FRAC_WIDTH = 16;

  // ****************************************
  // reset values and constants
  // ****************************************
  localparam logic [31:0] FACTOR_RST = 32'h0001_0000;
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  localparam logic [31:0] CAPTURE_RST = 32'h0000_0000;
  localparam logic [19:0] THRESH_RST = 20'h0_0000;
  localparam logic [10:0] CFG_RST = 11'h000;
  localparam logic [1:0] FLAGS_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [17:0] DEC_BASE = 18'h0_2710;

  typedef enum logic [1:0] {
    EDGE_LEVEL = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_mode_t;

endpackage

// [step_accum.sv]
`timescale 1ns/10ps

module step_accum (
  // operands
  input wire logic [31:0] count_in,
  input wire logic [15:0] frac_in,
  input wire logic [31:0] factor_in,
  input wire logic dec_in,
  input wire logic up_in,
  // result
  output logic [31:0] count_out,
  output logic [15:0] frac_out
);

  always_comb
  begin
    logic [47:0] fix;
    logic [47:0] ext;
    logic [31:0] whole;
    logic [17:0] dsum;
    logic carry;
    fix = 48'h0000_0000_0000;
    dsum = 18'h0_0000;
    carry = 1'h0;
    whole = {{16{factor_in[31]}}, factor_in[31:16]};
    // signed 16.16 factor sign-extended onto the 32.16 count
    ext = {{16{factor_in[31]}}, factor_in};
    if (up_in)
    begin
      fix = {count_in, frac_in} + ext;
      dsum = {2'h0, frac_in} + {2'h0, factor_in[15:0]};
      carry = (dsum >= enc_pos_pkg::DEC_BASE);
      if (carry)
      begin
        dsum = dsum - enc_pos_pkg::DEC_BASE;
      end
    end
    else
    begin
      fix = {count_in, frac_in} - ext;
      dsum = {2'h0, frac_in} - {2'h0, factor_in[15:0]};
      carry = dsum[17];
      if (carry)
      begin
        dsum = dsum + enc_pos_pkg::DEC_BASE;
      end
    end
    // decimal fraction counts in 1/10000, wraps by one base only
    if (dec_in)
    begin
      count_out = up_in ? count_in + whole + {31'h0000_0000, carry}
                        : count_in - whole - {31'h0000_0000, carry};
      frac_out = dsum[15:0];
    end
    else
    begin
      count_out = fix[47:16];
      frac_out = fix[15:0];
    end
  end

endmodule // step_accum

// [quad_front.sv]
`timescale 1ns/10ps

module quad_front (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // encoder pins, asynchronous
  input wire logic a_in,
  input wire logic b_in,
  input wire logic n_in,
  // index configuration
  input wire logic pol_a_in,
  input wire logic pol_b_in,
  input wire logic pol_n_in,
  input wire logic skip_quadrature_match_in,
  input wire enc_pos_pkg::edge_mode_t edge_mode_in,
  // decoded events
  output logic step_out,
  output logic up_out,
  output logic index_out
);

  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] sync;
    logic [1:0] ab_prev;
    logic match_prev;
    logic [2:0] prime;
  } front_state_t;

  front_state_t s;
  front_state_t next_s;
  logic match;

  always_comb
  begin
    next_s = s;
    next_s.meta = {n_in, b_in, a_in};
    next_s.sync = s.meta;
    next_s.ab_prev = s.sync[1:0];
    // pins are only trusted once both sync stages and the history are filled
    next_s.prime = {s.prime[1:0], 1'h1};
    match = (s.sync[2] == pol_n_in) &&
            (skip_quadrature_match_in ||
             ((s.sync[0] == pol_a_in) && (s.sync[1] == pol_b_in)));
    next_s.match_prev = match;
    step_out = s.prime[2] &&
               ((s.sync[0] ^ s.ab_prev[0]) ^ (s.sync[1] ^ s.ab_prev[1]));
    up_out = s.sync[0] ^ s.ab_prev[1];
    unique case (edge_mode_in)
      enc_pos_pkg::EDGE_LEVEL: index_out = match;
      enc_pos_pkg::EDGE_RISE: index_out = match & ~s.match_prev;
      enc_pos_pkg::EDGE_FALL: index_out = ~match & s.match_prev;
      enc_pos_pkg::EDGE_BOTH: index_out = match ^ s.match_prev;
    endcase
    index_out = index_out & s.prime[2];
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // up order in {b, a}: 00, 01, 11, 10
  chk_step_dir: assert property (@(posedge clk_in) disable iff (rst_in)
    step_out |-> up_out == (((s.ab_prev == 2'h0) && (s.sync[1:0] == 2'h1)) ||
                            ((s.ab_prev == 2'h1) && (s.sync[1:0] == 2'h3)) ||
                            ((s.ab_prev == 2'h3) && (s.sync[1:0] == 2'h2)) ||
                            ((s.ab_prev == 2'h2) && (s.sync[1:0] == 2'h0))))
    else $error("step direction does not follow quadrature order");

  chk_rise_single: assert property (@(posedge clk_in) disable iff (rst_in)
    (edge_mode_in == enc_pos_pkg::EDGE_RISE) && index_out
      |=> (edge_mode_in != enc_pos_pkg::EDGE_RISE) || !index_out)
    else $error("rising index event fired twice in a row");

endmodule // quad_front

// [encoder_position_monitor.sv]
// Functional notes
// - step factor is signed sixteen-dot-sixteen
// - each encoder step adds or subtracts factor
// - factor resets to one, one count per step
// - decimal select bit picks fraction base
// - index sets flag bit 0, write-one clears
// - slip flag bit 1 sticks while slipping
// - index copies count into capture register
// - twenty-bit slip threshold register
// - exceeding threshold warns, zero disables check
// - count is signed, readable and writable
// - decimal fraction 1/10000, binary 1/65536
// - continuous or one-shot capture, optional clear
// - index needs N polarity match, plus A and B unless skipped
`timescale 1ns/10ps

module encoder_position_monitor #(
  parameter int ADR_WIDTH = 10
) (
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  // wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [ADR_WIDTH-1:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // encoder pins
  input wire logic ENC_A_IN,
  input wire logic ENC_B_IN,
  input wire logic ENC_N_IN,
  // ramp generator
  input wire logic [31:0] RAMP_POSITION_IN,
  // interrupt
  output logic IRQ_OUT
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [enc_pos_pkg::CFG_WIDTH-1:0] cfg;
    logic [31:0] count;
    logic [15:0] frac;
    logic [31:0] factor;
    logic [enc_pos_pkg::FLAG_WIDTH-1:0] flags;
    logic [enc_pos_pkg::FLAG_WIDTH-1:0] mask;
    logic [31:0] capture;
    logic [enc_pos_pkg::THRESH_WIDTH-1:0] thresh;
    logic once_armed;
    logic irq;
  } mon_state_t;

  mon_state_t s;
  mon_state_t next_s;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old,
    input logic [31:0] wdat,
    input logic [3:0] sel
  );
    for (int i = 0; i < 4; i++)
    begin
      merge_bytes[8*i +: 8] = sel[i] ? wdat[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  function automatic logic [32:0] abs_gap(
    input logic [31:0] x,
    input logic [31:0] y
  );
    logic [32:0] d;
    d = {x[31], x} - {y[31], y};
    abs_gap = d[32] ? (33'h0_0000_0000 - d) : d;
  endfunction

  function automatic logic [31:0] read_word(
    input logic [7:0] idx,
    input mon_state_t st
  );
    unique case (idx)
      enc_pos_pkg::IDX_MASK: read_word = {30'h0000_0000, st.mask};
      enc_pos_pkg::IDX_CONFIG: read_word = {21'h00_0000, st.cfg};
      enc_pos_pkg::IDX_COUNT: read_word = st.count;
      enc_pos_pkg::IDX_FACTOR: read_word = st.factor;
      enc_pos_pkg::IDX_FLAGS: read_word = {30'h0000_0000, st.flags};
      enc_pos_pkg::IDX_CAPTURE: read_word = st.capture;
      enc_pos_pkg::IDX_THRESH: read_word = {12'h000, st.thresh};
      default: read_word = 32'h0000_0000;
    endcase
  endfunction

  // ****************************************
  // encoder front end and accumulator
  // ****************************************
  logic qf_step;
  logic qf_up;
  logic qf_index;
  logic [31:0] acc_count;
  logic [15:0] acc_frac;

  quad_front u_front (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .a_in(ENC_A_IN),
    .b_in(ENC_B_IN),
    .n_in(ENC_N_IN),
    .pol_a_in(s.cfg[enc_pos_pkg::CFG_POL_A]),
    .pol_b_in(s.cfg[enc_pos_pkg::CFG_POL_B]),
    .pol_n_in(s.cfg[enc_pos_pkg::CFG_POL_N]),
    .skip_quadrature_match_in(s.cfg[enc_pos_pkg::CFG_SKIP_QUAD]),
    .edge_mode_in(enc_pos_pkg::edge_mode_t'(s.cfg[enc_pos_pkg::CFG_EDGE_LSB +: 2])),
    .step_out(qf_step),
    .up_out(qf_up),
    .index_out(qf_index)
  );

  step_accum u_accum (
    .count_in(s.count),
    .frac_in(s.frac),
    .factor_in(s.factor),
    .dec_in(s.cfg[enc_pos_pkg::CFG_DECIMAL]),
    .up_in(qf_up),
    .count_out(acc_count),
    .frac_out(acc_frac)
  );

  // ****************************************
  // bus decode and event logic
  // ****************************************
  logic [7:0] idx;
  logic req;
  logic wr;
  logic [31:0] wdat;
  logic capture_now;
  logic clear_now;
  logic slip_cond;
  logic wr_count;
  logic wr_flags;
  logic wr_cfg;
  logic [31:0] cfg_merged;
  logic [31:0] thresh_merged;

  // the deviation check runs on the registered count, one cycle behind
  assign slip_cond = (s.thresh != 20'h0_0000) &&
                     (abs_gap(s.count, RAMP_POSITION_IN) >
                      {13'h0000, s.thresh});
  assign idx = WB_ADR_IN[9:2];
  assign req = WB_CYC_IN && WB_STB_IN;
  // writes land on the edge where ack is seen, as the master expects
  assign wr = req && WB_WE_IN && s.ack;
  assign wr_count = wr && (idx == enc_pos_pkg::IDX_COUNT);
  assign wr_flags = wr && (idx == enc_pos_pkg::IDX_FLAGS);
  assign wr_cfg = wr && (idx == enc_pos_pkg::IDX_CONFIG);
  assign capture_now = qf_index &&
                       (s.cfg[enc_pos_pkg::CFG_CONT] || s.once_armed);
  assign clear_now = capture_now && s.cfg[enc_pos_pkg::CFG_CLR_COUNT];
  assign cfg_merged = merge_bytes({21'h00_0000, s.cfg}, WB_DAT_IN, WB_SEL_IN);
  assign thresh_merged = merge_bytes({12'h000, s.thresh}, WB_DAT_IN, WB_SEL_IN);

  always_comb
  begin
    next_s = s;
    next_s.ack = req && !s.ack;
    wdat = WB_DAT_IN;
    if (req && !s.ack)
    begin
      next_s.rdata = read_word(idx, s);
    end

    if (qf_step)
    begin
      next_s.count = acc_count;
      next_s.frac = acc_frac;
    end

    if (capture_now)
    begin
      next_s.capture = s.count;
      next_s.once_armed = 1'h0;
    end
    if (clear_now)
    begin
      next_s.count = 32'h0000_0000;
      next_s.frac = 16'h0000;
    end

    if (wr)
    begin
      unique case (idx)
        enc_pos_pkg::IDX_MASK:
        begin
          next_s.mask = wdat[enc_pos_pkg::FLAG_WIDTH-1:0] & {2{WB_SEL_IN[0]}};
          next_s.mask = next_s.mask | (s.mask & {2{!WB_SEL_IN[0]}});
        end
        enc_pos_pkg::IDX_CONFIG:
        begin
          next_s.cfg = cfg_merged[enc_pos_pkg::CFG_WIDTH-1:0];
          // one-shot arms after any event in this same cycle
          next_s.once_armed = next_s.cfg[enc_pos_pkg::CFG_ONCE];
        end
        enc_pos_pkg::IDX_COUNT:
        begin
          // software write wins over a step or index clear
          next_s.count = merge_bytes(s.count, wdat, WB_SEL_IN);
          next_s.frac = 16'h0000;
        end
        enc_pos_pkg::IDX_FACTOR:
        begin
          next_s.factor = merge_bytes(s.factor, wdat, WB_SEL_IN);
        end
        enc_pos_pkg::IDX_FLAGS:
        begin
          next_s.flags = s.flags &
                         ~(wdat[enc_pos_pkg::FLAG_WIDTH-1:0] & {2{WB_SEL_IN[0]}});
        end
        enc_pos_pkg::IDX_THRESH:
        begin
          next_s.thresh = thresh_merged[enc_pos_pkg::THRESH_WIDTH-1:0];
        end
        default:
        begin
          next_s.mask = s.mask;
        end
      endcase
    end

    // events are applied after clears so a same-cycle set survives
    if (qf_index)
    begin
      next_s.flags[enc_pos_pkg::FLAG_INDEX] = 1'h1;
    end
    if (slip_cond)
    begin
      next_s.flags[enc_pos_pkg::FLAG_SLIP] = 1'h1;
    end
    next_s.irq = |(next_s.flags & next_s.mask);
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      s.ack <= 1'h0;
      s.rdata <= 32'h0000_0000;
      s.cfg <= enc_pos_pkg::CFG_RST;
      s.count <= enc_pos_pkg::COUNT_RST;
      s.frac <= 16'h0000;
      s.factor <= enc_pos_pkg::FACTOR_RST;
      s.flags <= enc_pos_pkg::FLAGS_RST;
      s.mask <= enc_pos_pkg::MASK_RST;
      s.capture <= enc_pos_pkg::CAPTURE_RST;
      s.thresh <= enc_pos_pkg::THRESH_RST;
      s.once_armed <= 1'h0;
      s.irq <= 1'h0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign WB_DAT_OUT = s.rdata;
  assign WB_ACK_OUT = s.ack;
  assign IRQ_OUT = s.irq;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (RST_IN);

  chk_ack_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack held for more than one cycle");

  chk_factor_reset: assert property ($past(RST_IN) |-> s.factor == 32'h0001_0000)
    else $error("step factor not one after reset");

  chk_unit_step: assert property (
    qf_step && (s.factor == 32'h0001_0000) && !s.cfg[enc_pos_pkg::CFG_DECIMAL]
      && !wr_count && !clear_now
      |=> s.count == ($past(qf_up) ? $past(s.count) + 32'h0000_0001
                                   : $past(s.count) - 32'h0000_0001))
    else $error("unit factor did not move count by one");

  chk_index_flag: assert property (qf_index |=> s.flags[enc_pos_pkg::FLAG_INDEX])
    else $error("index event lost");

  chk_index_clear: assert property (
    wr_flags && WB_SEL_IN[0] && wdat[0] && !qf_index
      |=> !s.flags[enc_pos_pkg::FLAG_INDEX])
    else $error("write one did not clear index flag");

  chk_slip_hold: assert property (slip_cond |=> s.flags[enc_pos_pkg::FLAG_SLIP])
    else $error("slip flag cleared while slip persists");

  chk_slip_off: assert property ((s.thresh == 20'h0_0000) && !s.flags[enc_pos_pkg::FLAG_SLIP]
    |=> !s.flags[enc_pos_pkg::FLAG_SLIP])
    else $error("slip check active with zero threshold");

  chk_capture_copy: assert property (capture_now |=> s.capture == $past(s.count))
    else $error("capture register missed the count");

  chk_dec_range: assert property (
    s.cfg[enc_pos_pkg::CFG_DECIMAL] && qf_step && !wr_count && !wr_cfg
      && (s.frac < 16'h2710) && (s.factor[15:0] < 16'h2710)
      |=> s.frac < 16'h2710)
    else $error("decimal fraction left its range");

  chk_irq_raise: assert property (
    qf_index && s.mask[enc_pos_pkg::FLAG_INDEX] && !(wr && (idx == enc_pos_pkg::IDX_MASK))
      |=> IRQ_OUT)
    else $error("unmasked index event raised no interrupt");

endmodule // encoder_position_monitor

// [quad_encoder_model.sv]
`timescale 1ns/10ps

// ****************************************
// quadrature encoder with index channel
// ****************************************
module quad_encoder_model (
  // clock
  input wire logic clk_in,
  // motion and index requests
  input wire logic step_up_in,
  input wire logic step_dn_in,
  input wire logic index_in,
  // encoder channels
  output logic a_out,
  output logic b_out,
  output logic n_out
);
  logic [1:0] phase = 2'h0;

  // one gray step per request: a single channel changes at a time
  always_ff @(posedge clk_in)
  begin
    if (step_up_in)
    begin
      phase <= phase + 2'h1;
    end
    else if (step_dn_in)
    begin
      phase <= phase - 2'h1;
    end
  end

  // a leads b going up: 00, 10, 11, 01
  assign a_out = (phase == 2'h1) || (phase == 2'h2);
  assign b_out = phase[1];
  assign n_out = index_in;
endmodule // quad_encoder_model

// [encoder_position_monitor_bench.sv]
`timescale 1ns/10ps

module encoder_position_monitor_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] sel = 4'h0;
  logic [3:0] lanes = 4'hF;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic enc_a;
  logic enc_b;
  logic enc_n;
  logic up_req = 1'b0;
  logic dn_req = 1'b0;
  logic idx_lvl = 1'b0;
  logic [31:0] ramp = 32'h0000_0000;
  logic [31:0] rv;
  int bad_count = 0;
  int checks_done = 0;

  always #10 clk = ~clk;

  encoder_position_monitor i_encoder_position_monitor (
    .MCLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
    .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
    .WB_ACK_OUT(ack), .ENC_A_IN(enc_a), .ENC_B_IN(enc_b), .ENC_N_IN(enc_n),
    .RAMP_POSITION_IN(ramp), .IRQ_OUT(irq)
  );

  quad_encoder_model i_quad_encoder_model (
    .clk_in(clk), .step_up_in(up_req), .step_dn_in(dn_req), .index_in(idx_lvl),
    .a_out(enc_a), .b_out(enc_b), .n_out(enc_n)
  );

  // ****************************************
  // bus access and comparison
  // ****************************************
  task automatic wb_cycle(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    sel <= lanes;
    adr <= {idx, 2'b00};
    wdat <= d;
    // only the watchdog ends a wait for ack
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    rv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    wb_cycle(1'b1, idx, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] e, input string nm);
    wb_cycle(1'b0, idx, 32'h0000_0000);
    chk(nm, e, rv);
  endtask

  // ****************************************
  // encoder stimulus
  // ****************************************
  // spacing of five cycles keeps one step per synchroniser window
  task automatic move(input int k, input logic up);
    repeat (k)
    begin
      @(posedge clk);
      up_req <= up;
      dn_req <= ~up;
      @(posedge clk);
      up_req <= 1'b0;
      dn_req <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask

  task automatic pulse_n();
    @(posedge clk);
    idx_lvl <= 1'b1;
    repeat (6) @(posedge clk);
    idx_lvl <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #500_000;
    bad_count++;
    results();
  end

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // flags first: idle pins match the reset index setting once decoding starts
    rd(enc_pos_pkg::IDX_FLAGS, 32'h0000_0000, "flags reset");
    rd(enc_pos_pkg::IDX_FACTOR, 32'h0001_0000, "factor reset");
    rd(enc_pos_pkg::IDX_CAPTURE, 32'h0000_0000, "capture reset");
    rd(enc_pos_pkg::IDX_THRESH, 32'h0000_0000, "thresh reset");
    rd(8'h40, 32'h0000_0000, "unmapped");
    repeat (4) @(posedge clk);
    move(5, 1'b1);
    rd(enc_pos_pkg::IDX_COUNT, 32'h0000_0005, "count up");
    move(2, 1'b0);
    rd(enc_pos_pkg::IDX_COUNT, 32'h0000_0003, "count down");
    wr(enc_pos_pkg::IDX_FACTOR, 32'hFFFE_0000);
    move(2, 1'b1);
    rd(enc_pos_pkg::IDX_COUNT, 32'hFFFF_FFFF, "negative factor");
    wr(enc_pos_pkg::IDX_COUNT, 32'h1234_5678);
    rd(enc_pos_pkg::IDX_COUNT, 32'h1234_5678, "count write");
    lanes = 4'h1;
    wr(enc_pos_pkg::IDX_COUNT, 32'hFFFF_FF9A);
    lanes = 4'hF;
    rd(enc_pos_pkg::IDX_COUNT, 32'h1234_569A, "count byte lane");
    wr(enc_pos_pkg::IDX_COUNT, 32'h0000_0000);
    wr(enc_pos_pkg::IDX_FACTOR, 32'h0000_8000);
    move(2, 1'b1);
    rd(enc_pos_pkg::IDX_COUNT, 32'h0000_0001, "binary half");
    wr(enc_pos_pkg::IDX_CONFIG, 32'h0000_0400);
    wr(enc_pos_pkg::IDX_COUNT, 32'h0000_0000);
    wr(enc_pos_pkg::IDX_FACTOR, 32'h0000_1388);
    move(2, 1'b1);
    rd(enc_pos_pkg::IDX_COUNT, 32'h0000_0001, "decimal half");
    // net nine steps: a high, b low from here on
    wr(enc_pos_pkg::IDX_CONFIG, 32'h0000_0057);
    wr(enc_pos_pkg::IDX_COUNT, 32'h0000_0064);
    // level events from the default setting left the index flag set
    wr(enc_pos_pkg::IDX_FLAGS, 32'h0000_0003);
    pulse_n();
    rd(enc_pos_pkg::IDX_FLAGS, 32'h0000_0000, "index b mismatch");
    wr(enc_pos_pkg::IDX_CONFIG, 32'h0000_0055);
    pulse_n();
    rd(enc_pos_pkg::IDX_FLAGS, 32'h0000_0001, "index flag");
    rd(enc_pos_pkg::IDX_CAPTURE, 32'h0000_0064, "capture");
    wr(enc_pos_pkg::IDX_MASK, 32'h0000_0003);
    @(posedge clk);
    chk("irq set", 1'b1, irq);
    wr(enc_pos_pkg::IDX_FLAGS, 32'h0000_0000);
    rd(enc_pos_pkg::IDX_FLAGS, 32'h0000_0001, "write zero keeps");
    wr(enc_pos_pkg::IDX_FLAGS, 32'h0000_0001);
    rd(enc_pos_pkg::IDX_FLAGS, 32'h0000_0000, "write one clears");
    chk("irq clear", 1'b0, irq);
    wr(enc_pos_pkg::IDX_CAPTURE, 32'h0BAD_0000);
    rd(enc_pos_pkg::IDX_CAPTURE, 32'h0000_0064, "capture read only");
    wr(enc_pos_pkg::IDX_CONFIG, 32'h0000_015C);
    wr(enc_pos_pkg::IDX_COUNT, 32'h0000_00C8);
    pulse_n();
    rd(enc_pos_pkg::IDX_CAPTURE, 32'h0000_00C8, "skip ab capture");
    rd(enc_pos_pkg::IDX_COUNT, 32'h0000_0000, "clear on index");
    wr(enc_pos_pkg::IDX_CONFIG, 32'h0000_006C);
    wr(enc_pos_pkg::IDX_COUNT, 32'h0000_012C);
    pulse_n();
    wr(enc_pos_pkg::IDX_COUNT, 32'h0000_0190);
    pulse_n();
    rd(enc_pos_pkg::IDX_CAPTURE, 32'h0000_012C, "once capture");
    wr(enc_pos_pkg::IDX_CONFIG, 32'h0000_0000);
    wr(enc_pos_pkg::IDX_THRESH, 32'hFFFF_FFFF);
    rd(enc_pos_pkg::IDX_THRESH, 32'h000F_FFFF, "thresh width");
    wr(enc_pos_pkg::IDX_THRESH, 32'h0000_000A);
    wr(enc_pos_pkg::IDX_FLAGS, 32'h0000_0003);
    wr(enc_pos_pkg::IDX_COUNT, 32'h0000_000B);
    rd(enc_pos_pkg::IDX_FLAGS, 32'h0000_0002, "slip set");
    chk("irq slip", 1'b1, irq);
    wr(enc_pos_pkg::IDX_FLAGS, 32'h0000_0002);
    rd(enc_pos_pkg::IDX_FLAGS, 32'h0000_0002, "slip persists");
    wr(enc_pos_pkg::IDX_COUNT, 32'h0000_000A);
    wr(enc_pos_pkg::IDX_FLAGS, 32'h0000_0002);
    rd(enc_pos_pkg::IDX_FLAGS, 32'h0000_0000, "slip at limit");
    @(posedge clk);
    ramp <= 32'hFFFF_FFFB;
    rd(enc_pos_pkg::IDX_FLAGS, 32'h0000_0002, "slip absolute");
    wr(enc_pos_pkg::IDX_THRESH, 32'h0000_0000);
    wr(enc_pos_pkg::IDX_FLAGS, 32'h0000_0002);
    rd(enc_pos_pkg::IDX_FLAGS, 32'h0000_0000, "slip disabled");
    results();
  end
endmodule // encoder_position_monitor_bench
